// file: shared/acs_defs.svh
// offsets, field positions, reset values and timing counts of the
// converter control block; included by the package and the design
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH

// register indexes; byte address is four times the index
`define ACS_IDX_RESULT 4'ha
`define ACS_IDX_CSR 4'hb

// control/status fields
`define ACS_CSR_DONE_BIT 7
`define ACS_CSR_RSVD_HI_BIT 6
`define ACS_CSR_ON_BIT 5
`define ACS_CSR_RSVD_LO_BIT 4
`define ACS_CSR_SEL_MSB 3
`define ACS_CSR_SEL_LSB 0

// reset values
`define ACS_RESULT_RST 8'h00
`define ACS_CSR_RST 8'h00

// converter clock is the cpu clock divided by this
`define ACS_CONV_CLK_DIV 4
// converter clock periods per conversion
`define ACS_CONV_PERIODS 12
// periods spent loading the sample capacitor
`define ACS_LOAD_PERIODS 4
// cpu cycles per conversion
`define ACS_CONV_CYCLES (`ACS_CONV_CLK_DIV * `ACS_CONV_PERIODS)

`endif

// file: shared/acs_pkg.sv
// types shared by the converter control block and its bench
// assumes acs_defs.svh sits on the include path
`include "acs_defs.svh"

package acs_pkg;

  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } acs_req_s;

  typedef struct packed {
    logic power_on;
    logic [3:0] input_select;
    logic sample;
    logic [7:0] trial_code;
  } acs_core_s;

  typedef enum logic [1:0] {
    ACS_IDLE,
    ACS_LOAD,
    ACS_APPROX
  } acs_state_e;

endpackage : acs_pkg

// file: logic/acs_top.sv
// control and status of an 8-bit successive approximation converter
// assumes an avalon-mm master on sys_clk (word addressed) and an analog
// core with a trial dac and a comparator output asynchronous to sys_clk
//
// How it works
// - done flag sets on finish, clears on control write or result read
// - done flag reads one only with fresh result
// - on bit powers converter up or down
// - four-bit select routes chosen analog input
// - read-only 8-bit result holds last value
// - both registers reset to all zeros
// - on bit starts continuous back-to-back conversions
// - control write with on bit set restarts conversion
// - twelve converter clocks, converter clock quarter
// - no interrupt; result valid until next
`include "acs_defs.svh"

module acs_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire acs_pkg::acs_req_s bus_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic comp_above,
  output acs_pkg::acs_core_s core_out
);

  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [7:0] result_reg;
  logic done_reg;
  logic on_reg;
  logic [3:0] sel_reg;
  logic stale_reg;
  logic [1:0] div_reg;
  logic [3:0] cnt_reg;
  logic [7:0] sar_reg;
  logic [7:0] sar_next;
  logic [7:0] trial_mask;
  logic comp_meta_reg;
  logic comp_sync_reg;
  acs_pkg::acs_state_e state_reg;
  acs_pkg::acs_core_s core_reg;

  logic req;
  logic accept;
  logic hit_result;
  logic hit_csr;
  logic csr_wr;
  logic result_rd;
  logic tick;
  logic complete;
  logic restart;
  logic [7:0] csr_view;

  assign req = bus_req.read | bus_req.write;
  assign accept = req & ~wait_reg;
  assign hit_result = bus_req.address == `ACS_IDX_RESULT;
  assign hit_csr = bus_req.address == `ACS_IDX_CSR;
  assign csr_wr = accept & bus_req.write & hit_csr & bus_req.byteenable[0];
  assign result_rd = accept & bus_req.read & hit_result;
  assign tick = div_reg == 2'(`ACS_CONV_CLK_DIV - 1);
  assign complete = tick & (state_reg == acs_pkg::ACS_APPROX)
    & (cnt_reg == 4'(`ACS_CONV_PERIODS - 1));
  assign restart = csr_wr & bus_req.writedata[`ACS_CSR_ON_BIT];

  // reserved positions always read as zero whatever software wrote
  always_comb begin
    csr_view = 8'h00;
    csr_view[`ACS_CSR_DONE_BIT] = done_reg;
    csr_view[`ACS_CSR_ON_BIT] = on_reg;
    csr_view[`ACS_CSR_SEL_MSB:`ACS_CSR_SEL_LSB] = sel_reg;
  end

  // one wait cycle per request; answer registered so outputs come from flops
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wait_reg <= 1'b1;
    end else if (req && wait_reg) begin
      wait_reg <= 1'b0;
    end else begin
      wait_reg <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else if (bus_req.read && wait_reg) begin
      if (hit_result) begin
        rdata_reg <= {24'h00_0000, result_reg};
      end else if (hit_csr) begin
        rdata_reg <= {24'h00_0000, csr_view};
      end else begin
        rdata_reg <= 32'h0000_0000;
      end
    end
  end

  // a result landing between snapshot and accept was not seen by the read
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stale_reg <= 1'b0;
    end else if (req && wait_reg) begin
      stale_reg <= complete;
    end else begin
      stale_reg <= 1'b0;
    end
  end

  // control fields; result register has no write path
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      on_reg <= 1'(`ACS_CSR_RST >> `ACS_CSR_ON_BIT);
      sel_reg <= 4'(`ACS_CSR_RST);
    end else if (csr_wr) begin
      on_reg <= bus_req.writedata[`ACS_CSR_ON_BIT];
      sel_reg <= bus_req.writedata[`ACS_CSR_SEL_MSB:`ACS_CSR_SEL_LSB];
    end
  end

  // set wins over any clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      done_reg <= 1'(`ACS_CSR_RST >> `ACS_CSR_DONE_BIT);
    end else if (complete) begin
      done_reg <= 1'b1;
    end else if (csr_wr || (result_rd && !stale_reg)) begin
      done_reg <= 1'b0;
    end
  end

  // loaded on the same edge as the flag; no interrupt is raised
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      result_reg <= `ACS_RESULT_RST;
    end else if (complete) begin
      result_reg <= sar_next;
    end
  end

  // comparator crosses from the analog core
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      comp_meta_reg <= 1'b0;
      comp_sync_reg <= 1'b0;
    end else begin
      comp_meta_reg <= comp_above;
      comp_sync_reg <= comp_meta_reg;
    end
  end

  // converter clock enable; realigned on restart so timing is exact
  always_ff @(posedge sys_clk) begin
    if (!rst_n || restart || state_reg == acs_pkg::ACS_IDLE) begin
      div_reg <= 2'd0;
    end else begin
      div_reg <= div_reg + 2'd1;
    end
  end

  // trial bit under test, msb first
  assign trial_mask = 8'h80 >> (cnt_reg - 4'(`ACS_LOAD_PERIODS));

  always_comb begin
    sar_next = comp_sync_reg ? sar_reg : (sar_reg & ~trial_mask);
    sar_next = sar_next | (trial_mask >> 1);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= acs_pkg::ACS_IDLE;
      cnt_reg <= 4'd0;
      sar_reg <= 8'h00;
    end else if (restart) begin
      state_reg <= acs_pkg::ACS_LOAD;
      cnt_reg <= 4'd0;
      sar_reg <= 8'h00;
    end else if (!on_reg) begin
      state_reg <= acs_pkg::ACS_IDLE;
      cnt_reg <= 4'd0;
      sar_reg <= 8'h00;
    end else if (tick || state_reg == acs_pkg::ACS_IDLE) begin
      case (state_reg)
        acs_pkg::ACS_IDLE: begin
          state_reg <= acs_pkg::ACS_LOAD;
          cnt_reg <= 4'd0;
        end
        acs_pkg::ACS_LOAD: begin
          cnt_reg <= cnt_reg + 4'd1;
          if (cnt_reg == 4'(`ACS_LOAD_PERIODS - 1)) begin
            state_reg <= acs_pkg::ACS_APPROX;
            sar_reg <= 8'h80;
          end
        end
        acs_pkg::ACS_APPROX: begin
          if (complete) begin
            state_reg <= acs_pkg::ACS_LOAD;
            cnt_reg <= 4'd0;
            sar_reg <= 8'h00;
          end else begin
            cnt_reg <= cnt_reg + 4'd1;
            sar_reg <= sar_next;
          end
        end
        default: begin
          state_reg <= acs_pkg::ACS_IDLE;
          cnt_reg <= 4'd0;
        end
      endcase
    end
  end

  // analog side; software is trusted to pick only bonded inputs
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      core_reg <= '0;
    end else begin
      core_reg.power_on <= on_reg;
      core_reg.input_select <= sel_reg;
      core_reg.sample <= state_reg == acs_pkg::ACS_LOAD;
      core_reg.trial_code <= sar_reg;
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;
  assign core_out = core_reg;

  // helper: cycles since the running conversion began
  logic [7:0] age_reg;
  always_ff @(posedge sys_clk) begin
    if (!rst_n || restart || complete || state_reg == acs_pkg::ACS_IDLE) begin
      age_reg <= 8'd0;
    end else begin
      age_reg <= age_reg + 8'd1;
    end
  end

  a_done_with_result: assert property (@(posedge sys_clk) disable iff (!rst_n)
    complete |=> done_reg && result_reg == $past(sar_next))
    else $error("result and done flag not updated together");

  a_done_means_fresh: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(done_reg) |-> $past(complete))
    else $error("done flag set without a finished conversion");

  a_write_clears_done: assert property (@(posedge sys_clk) disable iff (!rst_n)
    csr_wr && !complete |=> !done_reg)
    else $error("control write did not clear done flag");

  a_read_clears_done: assert property (@(posedge sys_clk) disable iff (!rst_n)
    result_rd && !stale_reg && !complete |=> !done_reg)
    else $error("result read did not clear done flag");

  // age is zero right after the starting edge, so it shows one less at the end
  a_conv_length: assert property (@(posedge sys_clk) disable iff (!rst_n)
    complete |-> age_reg == 8'(`ACS_CONV_CYCLES - 1))
    else $error("conversion length wrong");

  a_result_stable: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !complete |=> $stable(result_reg))
    else $error("result changed without a finished conversion");

  a_readdata_upper: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !wait_reg && bus_req.read |-> avs_readdata[31:8] == 24'h00_0000)
    else $error("read data wider than one byte");

  a_abort_restart: assert property (@(posedge sys_clk) disable iff (!rst_n)
    restart |=> state_reg == acs_pkg::ACS_LOAD && cnt_reg == 4'd0 ##1 core_out.sample)
    else $error("control write did not restart conversion");

  a_off_stays_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !on_reg && !restart |=> state_reg == acs_pkg::ACS_IDLE ##1 !core_out.power_on)
    else $error("converter running while off");

  a_reset_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(!rst_n) |-> result_reg == 8'h00 && csr_view == 8'h00)
    else $error("registers not zero after reset");

  a_select_follows: assert property (@(posedge sys_clk) disable iff (!rst_n)
    csr_wr |=> ##1 core_out.input_select == $past(bus_req.writedata[3:0], 2))
    else $error("input select not routed");

  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !wait_reg && bus_req.read && hit_csr |-> avs_readdata[6] == 1'b0 && avs_readdata[4] == 1'b0)
    else $error("reserved bit read as one");

  a_wait_answers: assert property (@(posedge sys_clk) disable iff (!rst_n)
    req && wait_reg |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");

  c_conversion_done: cover property (@(posedge sys_clk) disable iff (!rst_n) complete);
  c_back_to_back: cover property (@(posedge sys_clk) disable iff (!rst_n)
    complete ##[40:60] complete);
  c_abort: cover property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == acs_pkg::ACS_APPROX && restart);
  c_read_done: cover property (@(posedge sys_clk) disable iff (!rst_n) result_rd && done_reg);
  c_write_while_done: cover property (@(posedge sys_clk) disable iff (!rst_n) csr_wr && done_reg);

endmodule : acs_top

// file: sim/acs_core_model.sv
// analog core stand-in: channel n holds the level n*11h
// assumes core_out of the control block, on sys_clk
module acs_core_model (
  input wire logic sys_clk,
  input wire acs_pkg::acs_core_s core_out,
  output logic comp_above
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] level;
  logic idle_noise;
  initial idle_noise = 1'b0;
  assign level = {core_out.input_select, core_out.input_select};
  // a powered-down comparator means nothing, so it toggles
  always @(posedge sys_clk) begin
    idle_noise <= !idle_noise;
  end
  // analog comparator: settles within the cycle after each trial code change
  assign comp_above = core_out.power_on ? (level >= core_out.trial_code) : idle_noise;
endmodule : acs_core_model

// file: sim/adc_control_status_bench.sv
// self-checking bench of the converter control block
// assumes acs_core_model on the analog side
`include "acs_defs.svh"
module adc_control_status_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CONV = `ACS_CONV_CYCLES;
  typedef struct packed {logic [3:0] sel; logic [7:0] res;} acs_row_s;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  acs_pkg::acs_req_s bus_req = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic comp_above;
  acs_pkg::acs_core_s core_out;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  acs_row_s rows [4] = '{'{4'h0, 8'h00}, '{4'h5, 8'h55}, '{4'ha, 8'haa}, '{4'hf, 8'hff}};

  acs_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .bus_req(bus_req), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .comp_above(comp_above), .core_out(core_out));
  acs_core_model core (.sys_clk(sys_clk), .core_out(core_out), .comp_above(comp_above));

  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic finish_test();
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // request stands until waitrequest is sampled low
  // only the bench timeout ends a wait for the answer
  task automatic access(input logic wr, input logic [3:0] a, input logic [7:0] wd, output logic [31:0] d);
    @(posedge sys_clk);
    bus_req <= '{read: !wr, write: wr, address: a, writedata: {24'h0, wd}, byteenable: 4'hf};
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    bus_req <= '0;
  endtask : access

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] x;
    access(1'b1, a, d, x);
  endtask : wr

  task automatic rc(input string what, input logic [3:0] a, input logic [7:0] exp);
    logic [31:0] x;
    access(1'b0, a, 8'h00, x);
    chk(what, exp, x[7:0]);
    chk("readdata upper", 8'h00, {7'h0, |x[31:8]});
  endtask : rc

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      finish_test();
    end
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    rc("result", `ACS_IDX_RESULT, 8'h00);
    rc("csr", `ACS_IDX_CSR, 8'h00);
    foreach (rows[i]) begin
      wr(`ACS_IDX_CSR, 8'h20 | rows[i].sel);
      repeat (CONV + 8) @(posedge sys_clk);
      chk("power", 8'h01, {7'h0, core_out.power_on});
      chk("select", {4'h0, rows[i].sel}, {4'h0, core_out.input_select});
      rc("csr done", `ACS_IDX_CSR, 8'ha0 | rows[i].sel);
      rc("result", `ACS_IDX_RESULT, rows[i].res);
      rc("csr cleared", `ACS_IDX_CSR, 8'h20 | rows[i].sel);
    end
    repeat (CONV) @(posedge sys_clk);
    rc("csr again", `ACS_IDX_CSR, 8'haf);
    rc("result kept", `ACS_IDX_RESULT, 8'hff);
    // conversion length, measured from the enabling write
    wr(`ACS_IDX_CSR, 8'h23);
    repeat (2) @(posedge sys_clk);
    chk("sample", 8'h01, {7'h0, core_out.sample});
    repeat (16) @(posedge sys_clk);
    chk("first trial", 8'h80, core_out.trial_code);
    chk("sample off", 8'h00, {7'h0, core_out.sample});
    repeat (CONV - 26) @(posedge sys_clk);
    rc("csr early", `ACS_IDX_CSR, 8'h23);
    repeat (6) @(posedge sys_clk);
    rc("csr on time", `ACS_IDX_CSR, 8'ha3);
    // second write mid-conversion restarts the count
    repeat (30) @(posedge sys_clk);
    wr(`ACS_IDX_CSR, 8'h23);
    repeat (CONV - 12) @(posedge sys_clk);
    rc("csr aborted", `ACS_IDX_CSR, 8'h23);
    repeat (10) @(posedge sys_clk);
    rc("csr restarted", `ACS_IDX_CSR, 8'ha3);
    // reserved positions written as zero; a one written to the flag is ignored
    wr(`ACS_IDX_CSR, 8'haf);
    rc("csr reserved", `ACS_IDX_CSR, 8'h2f);
    wr(`ACS_IDX_CSR, 8'h07);
    wr(`ACS_IDX_RESULT, 8'h5a);
    repeat (CONV + 8) @(posedge sys_clk);
    chk("power off", 8'h00, {7'h0, core_out.power_on});
    rc("csr off", `ACS_IDX_CSR, 8'h07);
    rc("result ro", `ACS_IDX_RESULT, 8'h33);
    rc("unmapped", 4'h3, 8'h00);
    wr(`ACS_IDX_CSR, 8'h2c);
    repeat (CONV + 8) @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    rc("result reset", `ACS_IDX_RESULT, 8'h00);
    rc("csr reset", `ACS_IDX_CSR, 8'h00);
    finish_test();
  end
endmodule : adc_control_status_bench
